// >>> rtl/cu_map.svh
// Register offsets, field positions, reset values and counts of the crypto unit
`ifndef CU_MAP_SVH
`define CU_MAP_SVH
`define CU_OFS_ACCEL   8'h00
`define CU_OFS_MCFG    8'h04
`define CU_OFS_JBASE   8'h08
`define CU_OFS_JADD    8'h0C
`define CU_OFS_SMERR   8'h10
`define CU_OFS_PART    8'h14
`define CU_OFS_SMADDR  8'h18
`define CU_OFS_SMDATA  8'h1C
`define CU_OFS_ISTAT   8'h20
`define CU_OFS_IEN     8'h24
`define CU_OFS_ICLR    8'h28
`define CU_OFS_RESULT  8'h2C
`define CU_AES_LSB     0
`define CU_DES_LSB     4
`define CU_RC4_LSB     8
`define CU_AES_UNITS   4'h1
`define CU_DES_UNITS   4'h1
`define CU_RC4_UNITS   4'h1
`define CU_DEPTH_RST   2'h2
`define CU_IRQ_SMERR   0
`define CU_IRQ_DONE    1
`define CU_JQ_LEN      8'h01
`define CU_DE_LEN      8'h03
`define CU_JOB_STRIDE  32'h0000_0008
`define CU_FUSE_SETTLE 2'h3
`endif

// >>> rtl/cu_pkg.sv
// Types shared by the crypto unit design
package cu_pkg;
    typedef logic [31:0] cu_word_t;
    typedef enum logic [3:0] {
        JQ_IDLE = 4'h1,
        JQ_ADDR = 4'h2,
        JQ_DATA = 4'h4,
        JQ_HOLD = 4'h8
    } cu_jq_state_t;
    typedef enum logic [2:0] {
        DE_IDLE = 3'h1,
        DE_ADDR = 3'h2,
        DE_DATA = 3'h4
    } cu_de_state_t;
    typedef enum logic [1:0] {
        ERR_NONE  = 2'h0,
        ERR_SW_WR = 2'h1,
        ERR_SW_RD = 2'h2,
        ERR_BLOB  = 2'h3
    } cu_err_t;
    typedef enum logic {
        ID_JQ = 1'b0,
        ID_DE = 1'b1
    } cu_id_t;
endpackage

// >>> rtl/cu_top.sv
// Crypto unit: capability count, secure key memory and AXI read master
`timescale 1ns/1ps
`include "cu_map.svh"
module cu_top (
    input  wire logic            core_clk,
    input  wire logic            rstn,
    input  wire logic [7:0]      regAddr,
    input  cu_pkg::cu_word_t     regWdata,
    input  wire logic            regWr,
    input  wire logic            regRd,
    output cu_pkg::cu_word_t     regRdata,
    input  wire logic            fusePin,
    input  wire logic            blobWrite,
    input  wire logic [3:0]      blobAddr,
    input  cu_pkg::cu_word_t     blobData,
    input  wire logic            keyRead,
    input  wire logic [3:0]      keyAddr,
    output cu_pkg::cu_word_t     keyData,
    output logic                 arvalid,
    input  wire logic            arready,
    output cu_pkg::cu_word_t     araddr,
    output logic [0:0]           arid,
    output logic [7:0]           arlen,
    input  wire logic            rvalid,
    output logic                 rready,
    input  wire logic [0:0]      rid,
    input  cu_pkg::cu_word_t     rdata,
    input  wire logic            rlast,
    output logic                 irq
);
    import cu_pkg::*;

    function automatic logic partProt(input logic [3:0] cfg, input logic [3:0] a);
        partProt = cfg[{a[3], 1'b0}];
    endfunction

    function automatic logic partBlob(input logic [3:0] cfg, input logic [3:0] a);
        partBlob = cfg[{a[3], 1'b1}];
    endfunction

    // Fuse sync and one-time capture
    logic       fuseS1_reg, fuseS2_reg;
    logic [1:0] settle_reg, settle_next;
    logic       capDone_reg, capDone_next;
    logic       blown_reg, blown_next;
    logic [11:0] accelCount;

    always_comb begin
        settle_next  = settle_reg;
        capDone_next = capDone_reg;
        blown_next   = blown_reg;
        if (!capDone_reg) begin
            // Wait for the synchroniser to fill before trusting the fuse
            if (settle_reg == `CU_FUSE_SETTLE) begin
                capDone_next = 1'b1;
                blown_next   = fuseS2_reg;
            end else begin
                settle_next = settle_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fuseS1_reg  <= 1'b0;
            fuseS2_reg  <= 1'b0;
            settle_reg  <= 2'h0;
            capDone_reg <= 1'b0;
            blown_reg   <= 1'b1;
        end else begin
            fuseS1_reg  <= fusePin;
            fuseS2_reg  <= fuseS1_reg;
            settle_reg  <= settle_next;
            capDone_reg <= capDone_next;
            blown_reg   <= blown_next;
        end
    end

    // Unknown until captured, so report no units meanwhile
    assign accelCount = (blown_reg || !capDone_reg) ? 12'h000 :
        {`CU_RC4_UNITS, `CU_DES_UNITS, `CU_AES_UNITS};

    // Register file, secure memory and interrupts
    cu_word_t   smMem [16];
    logic [1:0] depth_reg, depth_next;
    logic [3:0] part_reg, part_next;
    logic [3:0] smAddr_reg, smAddr_next;
    cu_word_t   jobBase_reg, jobBase_next;
    logic [3:0] pending_reg, pending_next;
    cu_err_t    err_reg, err_next;
    logic [1:0] iStat_reg, iStat_next;
    logic [1:0] iEn_reg, iEn_next;
    cu_word_t   rdData_reg, rdData_next;
    cu_word_t   key_reg;
    logic       swWr, swRd, swDenyWr, swDenyRd, blobOk, errRead;
    logic       errSet, grantJq, grantDe, jobDone;
    cu_err_t    errNew;
    cu_word_t   result_reg;

    assign swWr     = regWr && regAddr == `CU_OFS_SMDATA;
    assign swRd     = regRd && regAddr == `CU_OFS_SMDATA;
    assign swDenyWr = swWr && partProt(part_reg, smAddr_reg);
    assign swDenyRd = swRd && partProt(part_reg, smAddr_reg);
    assign blobOk   = !partProt(part_reg, blobAddr) || partBlob(part_reg, blobAddr);
    assign errRead  = regRd && regAddr == `CU_OFS_SMERR;

    always_comb begin
        errSet = 1'b1;
        // Internal blob fault outranks a software fault in the same cycle
        if (blobWrite && !blobOk) begin
            errNew = ERR_BLOB;
        end else if (swDenyWr) begin
            errNew = ERR_SW_WR;
        end else if (swDenyRd) begin
            errNew = ERR_SW_RD;
        end else begin
            errNew = ERR_NONE;
            errSet = 1'b0;
        end
    end

    always_comb begin
        depth_next   = depth_reg;
        part_next    = part_reg;
        smAddr_next  = smAddr_reg;
        jobBase_next = jobBase_reg;
        pending_next = pending_reg;
        iEn_next     = iEn_reg;
        rdData_next  = 32'h0000_0000;
        if (grantJq) begin
            pending_next = pending_reg - 4'h1;
        end
        if (regWr) begin
            unique case (regAddr)
                `CU_OFS_MCFG:   depth_next = regWdata[1:0];
                `CU_OFS_JBASE:  jobBase_next = regWdata;
                `CU_OFS_JADD:   pending_next = pending_next + regWdata[3:0];
                `CU_OFS_PART:   part_next = regWdata[3:0];
                `CU_OFS_SMADDR: smAddr_next = regWdata[3:0];
                `CU_OFS_IEN:    iEn_next = regWdata[1:0];
                default:        ;
            endcase
        end
        if (regRd) begin
            unique case (regAddr)
                `CU_OFS_ACCEL:  rdData_next = {20'h0_0000, accelCount};
                `CU_OFS_MCFG:   rdData_next = {30'h0000_0000, depth_reg};
                `CU_OFS_JBASE:  rdData_next = jobBase_reg;
                `CU_OFS_JADD:   rdData_next = {28'h000_0000, pending_reg};
                `CU_OFS_SMERR:  rdData_next = {30'h0000_0000, err_reg};
                `CU_OFS_PART:   rdData_next = {28'h000_0000, part_reg};
                `CU_OFS_SMADDR: rdData_next = {28'h000_0000, smAddr_reg};
                `CU_OFS_SMDATA: rdData_next = swDenyRd ? 32'h0000_0000 : smMem[smAddr_reg];
                `CU_OFS_ISTAT:  rdData_next = {30'h0000_0000, iStat_reg};
                `CU_OFS_IEN:    rdData_next = {30'h0000_0000, iEn_reg};
                `CU_OFS_RESULT: rdData_next = result_reg;
                default:        rdData_next = 32'h0000_0000;
            endcase
        end
        // A new error wins over the clearing read
        err_next = errSet ? errNew : (errRead ? ERR_NONE : err_reg);
        iStat_next = iStat_reg;
        if (regWr && regAddr == `CU_OFS_ICLR) begin
            iStat_next = iStat_reg & ~regWdata[1:0];
        end
        iStat_next[`CU_IRQ_SMERR] = iStat_next[`CU_IRQ_SMERR] | errSet;
        iStat_next[`CU_IRQ_DONE]  = iStat_next[`CU_IRQ_DONE] | jobDone;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            depth_reg   <= `CU_DEPTH_RST;
            part_reg    <= 4'h0;
            smAddr_reg  <= 4'h0;
            jobBase_reg <= 32'h0000_0000;
            pending_reg <= 4'h0;
            err_reg     <= ERR_NONE;
            iStat_reg   <= 2'h0;
            iEn_reg     <= 2'h0;
            rdData_reg  <= 32'h0000_0000;
            key_reg     <= 32'h0000_0000;
        end else begin
            depth_reg   <= depth_next;
            part_reg    <= part_next;
            smAddr_reg  <= smAddr_next;
            jobBase_reg <= jobBase_next;
            pending_reg <= pending_next;
            err_reg     <= err_next;
            iStat_reg   <= iStat_next;
            iEn_reg     <= iEn_next;
            rdData_reg  <= rdData_next;
            if (keyRead) begin
                key_reg <= smMem[keyAddr];
            end
        end
    end

    // Blob port has the single write port first; a software write colliding with an accepted blob write is dropped
    always_ff @(posedge core_clk) begin
        if (blobWrite && blobOk) begin
            smMem[blobAddr] <= blobData;
        end else if (swWr && !swDenyWr) begin
            smMem[smAddr_reg] <= regWdata;
        end
    end

    assign regRdata = rdData_reg;
    assign keyData  = key_reg;
    assign irq      = |(iStat_reg & iEn_reg);

    // Job queue, descriptor executor and AR issue
    cu_jq_state_t jq_reg, jq_next;
    cu_de_state_t de_reg, de_next;
    logic [3:0]   jobIdx_reg, jobIdx_next;
    cu_word_t     ptr_reg, ptr_next, deAddr_reg, deAddr_next, result_next;
    logic [7:0]   jqBeat_reg, jqBeat_next, deBeat_reg, deBeat_next;
    logic         arValid_reg, arValid_next;
    cu_word_t     arAddr_reg, arAddr_next;
    logic [0:0]   arId_reg, arId_next;
    logic [7:0]   arLen_reg, arLen_next;
    logic [1:0]   outst, limit;
    logic         canIssue, beatJq, beatDe;

    // Depth 0 is treated as 1 so the master never stalls forever
    assign limit    = (depth_reg == 2'h0) ? 2'h1 : depth_reg;
    assign outst    = {1'b0, jq_reg == JQ_DATA} + {1'b0, de_reg == DE_DATA};
    assign canIssue = !arValid_reg && outst < limit;
    assign grantDe  = canIssue && de_reg == DE_ADDR;
    assign grantJq  = canIssue && jq_reg == JQ_ADDR && !grantDe;
    assign beatJq   = rvalid && rid == ID_JQ && jq_reg == JQ_DATA;
    assign beatDe   = rvalid && rid == ID_DE && de_reg == DE_DATA;
    assign jobDone  = beatDe && rlast;

    always_comb begin
        jq_next     = jq_reg;
        de_next     = de_reg;
        jobIdx_next = jobIdx_reg;
        ptr_next    = ptr_reg;
        deAddr_next = deAddr_reg;
        jqBeat_next = jqBeat_reg;
        deBeat_next = deBeat_reg;
        result_next = result_reg;
        unique case (jq_reg)
            JQ_IDLE: if (pending_reg != 4'h0) jq_next = JQ_ADDR;
            JQ_ADDR: if (grantJq) jq_next = JQ_DATA;
            JQ_DATA: begin
                if (beatJq) begin
                    jqBeat_next = jqBeat_reg + 8'h01;
                    if (jqBeat_reg == 8'h00) ptr_next = rdata;
                    if (rlast) jq_next = JQ_HOLD;
                end
            end
            JQ_HOLD: begin
                if (de_reg == DE_IDLE) begin
                    jq_next     = JQ_IDLE;
                    jqBeat_next = 8'h00;
                    jobIdx_next = jobIdx_reg + 4'h1;
                end
            end
        endcase
        unique case (de_reg)
            DE_IDLE: begin
                if (jq_reg == JQ_HOLD) begin
                    de_next     = DE_ADDR;
                    deAddr_next = ptr_reg;
                    deBeat_next = 8'h00;
                    result_next = 32'h0000_0000;
                end
            end
            DE_ADDR: if (grantDe) de_next = DE_DATA;
            DE_DATA: begin
                if (beatDe) begin
                    deBeat_next = deBeat_reg + 8'h01;
                    result_next = result_reg ^ rdata;
                    if (rlast) de_next = DE_IDLE;
                end
            end
        endcase
        arValid_next = arValid_reg && !arready;
        arAddr_next  = arAddr_reg;
        arId_next    = arId_reg;
        arLen_next   = arLen_reg;
        if (grantDe) begin
            arValid_next = 1'b1;
            arAddr_next  = deAddr_reg;
            arId_next    = ID_DE;
            arLen_next   = `CU_DE_LEN;
        end else if (grantJq) begin
            arValid_next = 1'b1;
            arAddr_next  = jobBase_reg + (32'(jobIdx_reg) * `CU_JOB_STRIDE);
            arId_next    = ID_JQ;
            arLen_next   = `CU_JQ_LEN;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            jq_reg      <= JQ_IDLE;
            de_reg      <= DE_IDLE;
            jobIdx_reg  <= 4'h0;
            ptr_reg     <= 32'h0000_0000;
            deAddr_reg  <= 32'h0000_0000;
            jqBeat_reg  <= 8'h00;
            deBeat_reg  <= 8'h00;
            result_reg  <= 32'h0000_0000;
            arValid_reg <= 1'b0;
            arAddr_reg  <= 32'h0000_0000;
            arId_reg    <= 1'b0;
            arLen_reg   <= 8'h00;
        end else begin
            jq_reg      <= jq_next;
            de_reg      <= de_next;
            jobIdx_reg  <= jobIdx_next;
            ptr_reg     <= ptr_next;
            deAddr_reg  <= deAddr_next;
            jqBeat_reg  <= jqBeat_next;
            deBeat_reg  <= deBeat_next;
            result_reg  <= result_next;
            arValid_reg <= arValid_next;
            arAddr_reg  <= arAddr_next;
            arId_reg    <= arId_next;
            arLen_reg   <= arLen_next;
        end
    end

    assign arvalid = arValid_reg;
    assign araddr  = arAddr_reg;
    assign arid    = arId_reg;
    assign arlen   = arLen_reg;
    assign rready  = 1'b1;

    chk_accel_read: assert property (@(posedge core_clk) disable iff (!rstn)
        regRd && regAddr == `CU_OFS_ACCEL |=> regRdata == {20'h0_0000, $past(accelCount)})
        else $error("capability read mismatch");
    chk_fuse_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        capDone_reg && fuseS2_reg && !$past(capDone_reg) |-> accelCount == 12'h000)
        else $error("blown fuse shows units");
    chk_cap_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        capDone_reg |=> $stable(accelCount) && capDone_reg)
        else $error("capability changed after capture");
    chk_sw_deny: assert property (@(posedge core_clk) disable iff (!rstn)
        swDenyWr && !blobWrite |=> err_reg == ERR_SW_WR)
        else $error("denied write not logged");
    chk_blob_lands: assert property (@(posedge core_clk) disable iff (!rstn)
        blobWrite && blobOk |=> smMem[$past(blobAddr)] == $past(blobData))
        else $error("blob write lost");
    chk_blob_noerr: assert property (@(posedge core_clk) disable iff (!rstn)
        blobWrite && blobOk && !swDenyWr && !swDenyRd && !errRead |=> $stable(err_reg))
        else $error("false error on blob write");
    chk_err_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        errRead && !errSet |=> err_reg == ERR_NONE)
        else $error("error not cleared by read");
    chk_depth_one: assert property (@(posedge core_clk) disable iff (!rstn)
        depth_reg == 2'h1 && $stable(depth_reg) |-> outst <= 2'h1)
        else $error("too many outstanding");
    chk_jq_submit: assert property (@(posedge core_clk) disable iff (!rstn)
        grantJq |-> pending_reg != 4'h0)
        else $error("fetch without submitted job");
    chk_beat_steer: assert property (@(posedge core_clk) disable iff (!rstn)
        beatJq && rlast |=> jq_reg == JQ_HOLD ##0 de_reg == $past(de_next))
        else $error("beat steering wrong");
    chk_ar_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        arvalid && !arready |=> arvalid && $stable(araddr) && $stable(arid))
        else $error("AR dropped before accept");
endmodule

// >>> testbench/cu_axi_slave.sv
// Read-only AXI slave standing in for the interconnect and memory controllers
`timescale 1ns/1ps
module cu_axi_slave (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        slow,
    input  wire logic        arvalid,
    output logic             arready,
    input  cu_pkg::cu_word_t araddr,
    input  wire logic [0:0]  arid,
    input  wire logic [7:0]  arlen,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [0:0]       rid,
    output cu_pkg::cu_word_t rdata,
    output logic             rlast
);
    import cu_pkg::*;
    logic          busy [2];
    cu_word_t      base [2];
    logic [7:0]    len  [2];
    logic [7:0]    cnt  [2];
    logic          turn;
    logic          gap;

    // Memory image: word at address a reads a + 0x1000
    always_ff @(posedge clk or negedge rstn) begin
        logic sel;
        if (!rstn) begin
            busy    <= '{1'b0, 1'b0};
            cnt     <= '{8'h00, 8'h00};
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rid     <= 1'b0;
            rdata   <= 32'h0000_0000;
            rlast   <= 1'b0;
            turn    <= 1'b0;
            gap     <= 1'b0;
        end else begin
            gap <= slow ? ~gap : 1'b0;
            if (arvalid && arready) begin
                busy[arid] <= 1'b1;
                base[arid] <= araddr;
                len[arid]  <= arlen;
                cnt[arid]  <= 8'h00;
                arready    <= 1'b0;
            end else begin
                arready <= arvalid && !busy[arid] && !gap;
            end
            if (rvalid && !rready) begin
                rvalid <= 1'b1;
            end else if (!gap && (busy[0] || busy[1])) begin
                // Alternate ids so beats of two transactions interleave
                sel    = busy[turn] ? turn : !turn;
                rvalid <= 1'b1;
                rid    <= sel;
                rdata  <= base[sel] + {22'h0, cnt[sel], 2'b00} + 32'h0000_1000;
                rlast  <= (cnt[sel] == len[sel]);
                if (cnt[sel] == len[sel])
                    busy[sel] <= 1'b0;
                else
                    cnt[sel] <= cnt[sel] + 8'h01;
                turn <= !sel;
            end else begin
                // Released lines do not keep the last beat
                rvalid <= 1'b0;
                rdata  <= ~rdata;
                rid    <= ~rid;
                rlast  <= ~rlast;
            end
        end
    end
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the crypto unit
`timescale 1ns/1ps
`include "cu_map.svh"
module tb_top;
    import cu_pkg::*;
    logic       core_clk, rstn, regWr, regRd, fusePin, blobWrite, keyRead, slowMode;
    logic [7:0] regAddr;
    logic [3:0] blobAddr, keyAddr;
    cu_word_t   regWdata, regRdata, blobData, keyData, araddr, rdata, rdVal, ptr, xorAcc, lastXor;
    logic       arvalid, arready, rvalid, rready, rlast, irq, jqFirst;
    logic [0:0] arid, rid;
    logic [7:0] arlen;
    int         errors, checked, outst, maxOut, jqCnt, doneCnt;
    cu_word_t   ptrQ[$];

    cu_top i_dut (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .fusePin(fusePin), .blobWrite(blobWrite), .blobAddr(blobAddr),
        .blobData(blobData), .keyRead(keyRead), .keyAddr(keyAddr), .keyData(keyData), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arid(arid), .arlen(arlen), .rvalid(rvalid), .rready(rready),
        .rid(rid), .rdata(rdata), .rlast(rlast), .irq(irq));
    cu_axi_slave i_mem (.clk(core_clk), .rstn(rstn), .slow(slowMode), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arid(arid), .arlen(arlen), .rvalid(rvalid), .rready(rready), .rid(rid),
        .rdata(rdata), .rlast(rlast));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input cu_word_t seen, input cu_word_t exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic regWrite(input logic [7:0] a, input cu_word_t d);
        @(posedge core_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        // Let the register update settle before anyone looks at irq
        #1;
    endtask

    task automatic regRead(input logic [7:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 rdVal = regRdata;
    endtask

    task automatic internalOp(input logic wr, input logic [3:0] a, input cu_word_t d);
        @(posedge core_clk);
        blobWrite <= wr;
        keyRead   <= !wr;
        blobAddr  <= a;
        keyAddr   <= a;
        blobData  <= d;
        @(posedge core_clk);
        blobWrite <= 1'b0;
        keyRead   <= 1'b0;
        #1;
    endtask

    task automatic doReset(input logic fuse);
        rstn    <= 1'b0;
        fusePin <= fuse;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        // Fuse is captured on the fourth edge after release
        repeat (6) @(posedge core_clk);
    endtask

    // Capability fields from the captured fuse, read-only, steady afterwards
    task automatic testCapability(input logic fuse, input cu_word_t exp);
        doReset(fuse);
        regRead(`CU_OFS_ACCEL);
        check("capability", rdVal, exp);
        fusePin <= !fuse;
        regWrite(`CU_OFS_ACCEL, 32'hFFFF_FFFF);
        repeat (8) @(posedge core_clk);
        regRead(`CU_OFS_ACCEL);
        check("capability held", rdVal, exp);
    endtask

    // Protected partition, blob permission, clear-on-read error and interrupt
    task automatic testSecure();
        regWrite(`CU_OFS_PART, 32'h0000_0000);
        regWrite(`CU_OFS_SMADDR, 32'h0000_0002);
        regWrite(`CU_OFS_SMDATA, 32'h1234_5678);
        regWrite(`CU_OFS_PART, 32'h0000_0001);
        regWrite(`CU_OFS_SMDATA, 32'hDEAD_BEEF);
        regRead(`CU_OFS_SMERR);
        check("error sw write", rdVal, 32'h0000_0001);
        regRead(`CU_OFS_SMERR);
        check("error cleared", rdVal, 32'h0000_0000);
        regRead(`CU_OFS_SMDATA);
        check("window read", rdVal, 32'h0000_0000);
        regRead(`CU_OFS_SMERR);
        check("error sw read", rdVal, 32'h0000_0002);
        internalOp(1'b0, 4'h2, 32'h0000_0000);
        check("key read", keyData, 32'h1234_5678);
        internalOp(1'b1, 4'h2, 32'hCAFE_F00D);
        regRead(`CU_OFS_SMERR);
        check("error blob", rdVal, 32'h0000_0003);
        internalOp(1'b0, 4'h2, 32'h0000_0000);
        check("blob refused", keyData, 32'h1234_5678);
        regWrite(`CU_OFS_PART, 32'h0000_0003);
        internalOp(1'b1, 4'h2, 32'hCAFE_F00D);
        internalOp(1'b0, 4'h2, 32'h0000_0000);
        check("blob written", keyData, 32'hCAFE_F00D);
        regRead(`CU_OFS_SMERR);
        check("no false error", rdVal, 32'h0000_0000);
        regWrite(`CU_OFS_IEN, 32'h0000_0000);
        check("irq masked", {31'h0, irq}, 32'h0000_0000);
        regWrite(`CU_OFS_IEN, 32'h0000_0001);
        check("irq raised", {31'h0, irq}, 32'h0000_0001);
        regWrite(`CU_OFS_ICLR, 32'h0000_0001);
        check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    endtask

    // Submit jobs and judge outstanding depth, prefetch and the result
    task automatic testJobs(input logic [1:0] depth, input int n, input logic slow);
        int target;
        int jq0;
        regWrite(`CU_OFS_MCFG, {30'h0, depth});
        // Drop the sticky done bit so each run must set it anew
        regWrite(`CU_OFS_ICLR, 32'h0000_0002);
        slowMode <= slow;
        target = doneCnt + n;
        jq0    = jqCnt;
        maxOut = 0;
        regWrite(`CU_OFS_JADD, n);
        for (int i = 0; i < 4000 && doneCnt < target; i++)
            @(posedge core_clk);
        repeat (40) @(posedge core_clk);
        check("jobs done", doneCnt, target);
        check("job fetches", jqCnt - jq0, n);
        check("beat accept", {31'h0, rready}, 32'h0000_0001);
        check("depth kept", {31'h0, maxOut <= ((depth == 2'h0) ? 2'h1 : depth)}, 32'h0000_0001);
        regRead(`CU_OFS_RESULT);
        check("result", rdVal, lastXor);
        regRead(`CU_OFS_ISTAT);
        check("done status", rdVal & 32'h0000_0002, 32'h0000_0002);
    endtask

    always @(posedge core_clk) begin
        if (!rstn) begin
            outst = 0;
            xorAcc = 32'h0;
            ptrQ.delete();
        end else begin
            if (arvalid && arready) begin
                outst++;
                if (arid == 1'b0) begin
                    jqCnt++;
                    jqFirst = 1'b1;
                    check("fetch address", araddr, 32'h0000_4000 + (jqCnt - 1) * `CU_JOB_STRIDE);
                    check("fetch length", {24'h0, arlen}, {24'h0, `CU_JQ_LEN});
                end else begin
                    ptr = (ptrQ.size() > 0) ? ptrQ.pop_front() : 32'h0;
                    check("exec address", araddr, ptr);
                    check("exec length", {24'h0, arlen}, {24'h0, `CU_DE_LEN});
                end
            end
            if (rvalid && rready) begin
                if (rid == 1'b0 && jqFirst) begin
                    ptrQ.push_back(rdata);
                    jqFirst = 1'b0;
                end
                if (rid == 1'b1) begin
                    xorAcc = xorAcc ^ rdata;
                    if (rlast) begin
                        lastXor = xorAcc;
                        xorAcc = 32'h0;
                        doneCnt++;
                    end
                end
                if (rlast)
                    outst--;
            end
            if (outst > maxOut)
                maxOut = outst;
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        complete_run();
    end

    initial begin
        {regWr, regRd, blobWrite, keyRead, slowMode, jqFirst} = '0;
        {regAddr, blobAddr, keyAddr} = '0;
        {regWdata, blobData} = '0;
        fusePin = 1'b0;
        rstn = 1'b0;
        {errors, checked, jqCnt, doneCnt, maxOut} = '0;
        lastXor = 32'h0;
        testCapability(1'b1, 32'h0000_0000);
        testCapability(1'b0, {20'h0, `CU_RC4_UNITS, `CU_DES_UNITS, `CU_AES_UNITS});
        testSecure();
        regWrite(`CU_OFS_JBASE, 32'h0000_4000);
        testJobs(2'h1, 2, 1'b1);
        testJobs(2'h2, 3, 1'b0);
        testJobs(2'h1, 1, 1'b0);
        testJobs(2'h0, 1, 1'b0);
        complete_run();
    end
endmodule
